// ---- lfac_lock_fuse.sv ----
`timescale 1ns/1ps
`include "lfac_regs.svh"
// Operation
// - Unlocked only when key equals unlock value.
// - Any other programmed key locks device.
// - Locked: debug port refused except row write.
// - Refused debug reads return invalid data.
// - Locked debug may write, not read, row.
// - Only full erase leaves locked state.
// - CPU access unchanged by lock state.
// - Fuses readable by both, written by debug.
// - Fuses copied to targets during start-up.
// - Fuse changes apply only after reset.
module lfac_lock_fuse
	import lfac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        nvm_key_valid,
	input  wire logic [31:0] nvm_key,
	input  wire logic [71:0] nvm_fuses,
	input  wire logic        dbg_valid,
	input  wire lfac_req_t   dbg_req,
	input  wire logic        dbg_erase,
	input  wire logic [7:0]  dbg_raw_rdata,
	input  wire logic        cpu_valid,
	input  wire lfac_req_t   cpu_req,
	input  wire logic [7:0]  cpu_raw_rdata,
	output logic             locked,
	output logic             startup_done,
	output logic             erase_busy,
	output logic             dbg_grant,
	output logic [7:0]       dbg_rdata,
	output logic             cpu_grant,
	output logic [7:0]       cpu_rdata,
	output logic [7:0]       watchdog_config_fuse,
	output logic [7:0]       brownout_config_fuse,
	output logic [7:0]       oscillator_config_fuse,
	output logic [7:0]       system_config_fuse_a,
	output logic [7:0]       system_config_fuse_b,
	output logic [7:0]       application_section_end_fuse,
	output logic [7:0]       loader_section_end_fuse
);
	// ==========================================================
	// Start-up and erase sequencing
	lfac_state_t state_reg;
	logic [31:0] lock_key_reg;
	logic        d_grant_c;
	logic [7:0]  d_rdata_c;
	logic        c_grant_c;
	logic [7:0]  c_rdata_c;
	logic        dbg_ok;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= LFAC_ST_LOAD;
		end else begin
			unique case (state_reg)
				LFAC_ST_LOAD:  if (nvm_key_valid) state_reg <= LFAC_ST_EVAL;
				LFAC_ST_EVAL:  state_reg <= LFAC_ST_RUN;
				LFAC_ST_RUN:   if (dbg_erase) state_reg <= LFAC_ST_ERASE;
				LFAC_ST_ERASE: state_reg <= LFAC_ST_RUN;
			endcase
		end
	end

	// The key register defaults to a locked value so nothing leaks before load.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			lock_key_reg <= 32'h00000000;
		else if (state_reg == LFAC_ST_LOAD && nvm_key_valid)
			lock_key_reg <= nvm_key;
		else if (state_reg == LFAC_ST_ERASE)
			lock_key_reg <= `LFAC_UNLOCK_KEY;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			locked       <= 1'b1;
			startup_done <= 1'b0;
			erase_busy   <= 1'b0;
		end else begin
			locked       <= (lock_key_reg != `LFAC_UNLOCK_KEY);
			startup_done <= (state_reg == LFAC_ST_RUN);
			erase_busy   <= (state_reg == LFAC_ST_ERASE) || (state_reg == LFAC_ST_RUN && dbg_erase);
		end
	end

	// ==========================================================
	// Fuse copy into targets, once per reset
	// Fuses held in NVM may change later; targets only follow after the next reset.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			watchdog_config_fuse         <= `LFAC_ERASED_BYTE;
			brownout_config_fuse         <= `LFAC_ERASED_BYTE;
			oscillator_config_fuse       <= `LFAC_ERASED_BYTE;
			system_config_fuse_a         <= `LFAC_ERASED_BYTE;
			system_config_fuse_b         <= `LFAC_ERASED_BYTE;
			application_section_end_fuse <= `LFAC_ERASED_BYTE;
			loader_section_end_fuse      <= `LFAC_ERASED_BYTE;
		end else if (state_reg == LFAC_ST_EVAL) begin
			watchdog_config_fuse         <= nvm_fuses[8*`LFAC_FUSE_WDT_OFS +: 8];
			brownout_config_fuse         <= nvm_fuses[8*`LFAC_FUSE_BOD_OFS +: 8];
			oscillator_config_fuse       <= nvm_fuses[8*`LFAC_FUSE_OSC_OFS +: 8];
			system_config_fuse_a         <= nvm_fuses[8*`LFAC_FUSE_SYSA_OFS +: 8];
			system_config_fuse_b         <= nvm_fuses[8*`LFAC_FUSE_SYSB_OFS +: 8];
			application_section_end_fuse <= nvm_fuses[8*`LFAC_FUSE_APPEND_OFS +: 8];
			loader_section_end_fuse      <= nvm_fuses[8*`LFAC_FUSE_LDREND_OFS +: 8];
		end
	end

	// ==========================================================
	// Access gates
	lfac_gate #(.IS_DEBUG(1'b1)) u_dbg_gate (
		.locked    (locked),
		.req_valid (dbg_valid),
		.req       (dbg_req),
		.raw_rdata (dbg_raw_rdata),
		.grant     (d_grant_c),
		.rdata     (d_rdata_c)
	);

	lfac_gate #(.IS_DEBUG(1'b0)) u_cpu_gate (
		.locked    (locked),
		.req_valid (cpu_valid),
		.req       (cpu_req),
		.raw_rdata (cpu_raw_rdata),
		.grant     (c_grant_c),
		.rdata     (c_rdata_c)
	);

	// Debug grants wait for the evaluated lock state; erase owns the array.
	assign dbg_ok = (state_reg == LFAC_ST_RUN) && startup_done && !dbg_erase;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dbg_grant <= 1'b0;
			dbg_rdata <= `LFAC_LOCKED_FILL;
			cpu_grant <= 1'b0;
			cpu_rdata <= 8'h00;
		end else begin
			dbg_grant <= d_grant_c && dbg_ok;
			dbg_rdata <= dbg_ok ? d_rdata_c : `LFAC_LOCKED_FILL;
			cpu_grant <= c_grant_c;
			cpu_rdata <= c_rdata_c;
		end
	end

	// ==========================================================
	// Checks
	sequence s_erase_req;
		state_reg == LFAC_ST_RUN && dbg_erase;
	endsequence

	// Busy stands for the request edge and for the key rewrite that follows it.
	sequence s_erase_busy;
		erase_busy ##1 erase_busy;
	endsequence

	chk_unlock_key_value: assert property (@(posedge clk) disable iff (sys_rst)
		!locked |-> $past(lock_key_reg) == `LFAC_UNLOCK_KEY)
		else $error("Unlocked with a foreign key.");
	chk_locked_refuse: assert property (@(posedge clk) disable iff (sys_rst)
		dbg_grant |-> !$past(locked) || ($past(dbg_req.wr) && $past(dbg_req.sec) == LFAC_SEC_END_PRODUCT_DATA_ROW))
		else $error("Locked debug access granted.");
	chk_refused_fill: assert property (@(posedge clk) disable iff (sys_rst)
		!dbg_grant |-> dbg_rdata == `LFAC_LOCKED_FILL)
		else $error("Refused read leaked data.");
	chk_row_write_ok: assert property (@(posedge clk) disable iff (sys_rst)
		dbg_valid && dbg_req.wr && dbg_req.sec == LFAC_SEC_END_PRODUCT_DATA_ROW && dbg_ok |=> dbg_grant)
		else $error("Row write refused.");
	chk_erase_unlocks: assert property (@(posedge clk) disable iff (sys_rst)
		s_erase_req |-> ##3 !locked)
		else $error("Erase did not unlock.");
	chk_stay_locked: assert property (@(posedge clk) disable iff (sys_rst)
		locked && $stable(state_reg) && state_reg == LFAC_ST_RUN |=> locked)
		else $error("Left lock without erase.");
	chk_cpu_no_fuse_wr: assert property (@(posedge clk) disable iff (sys_rst)
		cpu_valid && cpu_req.wr && cpu_req.sec == LFAC_SEC_FUSE |=> !cpu_grant)
		else $error("CPU wrote fuses.");
	chk_cpu_reads: assert property (@(posedge clk) disable iff (sys_rst)
		cpu_valid && !cpu_req.wr |=> cpu_grant)
		else $error("CPU read refused.");
	chk_fuse_hold: assert property (@(posedge clk) disable iff (sys_rst)
		state_reg == LFAC_ST_RUN |=> $stable(watchdog_config_fuse) && $stable(brownout_config_fuse) &&
			$stable(oscillator_config_fuse) && $stable(system_config_fuse_a) && $stable(system_config_fuse_b) &&
			$stable(application_section_end_fuse) && $stable(loader_section_end_fuse))
		else $error("Fuse target changed while running.");
	chk_fuse_copy: assert property (@(posedge clk) disable iff (sys_rst)
		state_reg == LFAC_ST_EVAL |=>
			watchdog_config_fuse == $past(nvm_fuses[7:0]) && brownout_config_fuse == $past(nvm_fuses[15:8]) &&
			oscillator_config_fuse == $past(nvm_fuses[23:16]) && system_config_fuse_a == $past(nvm_fuses[47:40]) &&
			system_config_fuse_b == $past(nvm_fuses[55:48]) &&
			application_section_end_fuse == $past(nvm_fuses[63:56]) && loader_section_end_fuse == $past(nvm_fuses[71:64]))
		else $error("Fuse not copied.");

	// ==========================================================
	// Start-up, erase and port checks
	chk_startup_gate: assert property (@(posedge clk) disable iff (sys_rst)
		!startup_done |=> !dbg_grant)
		else $error("Debug granted before start-up.");
	chk_key_load: assert property (@(posedge clk) disable iff (sys_rst)
		state_reg == LFAC_ST_LOAD && nvm_key_valid |=> lock_key_reg == $past(nvm_key))
		else $error("Lock key not loaded.");
	chk_erase_busy: assert property (@(posedge clk) disable iff (sys_rst)
		s_erase_req |=> s_erase_busy)
		else $error("Erase busy missing.");
	chk_erase_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		erase_busy |-> !dbg_grant)
		else $error("Debug granted during erase.");
	chk_locked_fill: assert property (@(posedge clk) disable iff (sys_rst)
		dbg_valid && !dbg_req.wr && locked |=> dbg_rdata == `LFAC_LOCKED_FILL)
		else $error("Locked read returned data.");
	chk_cpu_no_id_wr: assert property (@(posedge clk) disable iff (sys_rst)
		cpu_valid && cpu_req.wr && cpu_req.sec == LFAC_SEC_FACTORY_ID_ROW |=> !cpu_grant)
		else $error("CPU wrote the factory row.");
	chk_dbg_fuse_wr: assert property (@(posedge clk) disable iff (sys_rst)
		dbg_valid && dbg_req.wr && dbg_req.sec == LFAC_SEC_FUSE && dbg_ok && !locked |=> dbg_grant)
		else $error("Unlocked fuse write refused.");
endmodule // lfac_lock_fuse

// ---- lfac_regs.svh ----
`ifndef LFAC_REGS_SVH
`define LFAC_REGS_SVH
// ==========================================================
// Lock key
`define LFAC_LOCK_KEY_OFS      4'h0
`define LFAC_UNLOCK_KEY        32'h5cc5c55c
`define LFAC_LOCKED_FILL       8'hff
// ==========================================================
// Fuse bank byte offsets
`define LFAC_FUSE_WDT_OFS      4'h0
`define LFAC_FUSE_BOD_OFS      4'h1
`define LFAC_FUSE_OSC_OFS      4'h2
`define LFAC_FUSE_RSV3_OFS     4'h3
`define LFAC_FUSE_RSV4_OFS     4'h4
`define LFAC_FUSE_SYSA_OFS     4'h5
`define LFAC_FUSE_SYSB_OFS     4'h6
`define LFAC_FUSE_APPEND_OFS   4'h7
`define LFAC_FUSE_LDREND_OFS   4'h8
`define LFAC_FUSE_COUNT        9
`define LFAC_ERASED_BYTE       8'hff
`endif

// ---- lfac_pkg.sv ----
package lfac_pkg;
	typedef enum logic [2:0] {
		LFAC_SEC_FLASH                = 3'h0,
		LFAC_SEC_SRAM                 = 3'h1,
		LFAC_SEC_EEPROM               = 3'h2,
		LFAC_SEC_END_PRODUCT_DATA_ROW = 3'h3,
		LFAC_SEC_FACTORY_ID_ROW       = 3'h4,
		LFAC_SEC_FUSE                 = 3'h5,
		LFAC_SEC_LOCK                 = 3'h6,
		LFAC_SEC_REGS                 = 3'h7
	} lfac_section_t;

	// A memory request: section, byte address, write flag, write data.
	typedef struct packed {
		lfac_section_t sec;
		logic [15:0]   addr;
		logic          wr;
		logic [7:0]    wdata;
	} lfac_req_t;

	typedef enum logic [1:0] {
		LFAC_ST_LOAD  = 2'b00,
		LFAC_ST_EVAL  = 2'b01,
		LFAC_ST_RUN   = 2'b11,
		LFAC_ST_ERASE = 2'b10
	} lfac_state_t;
endpackage

// ---- lfac_gate.sv ----
`timescale 1ns/1ps
`include "lfac_regs.svh"
// ==========================================================
// One access gate: decides grant and shapes read data for one requester.
module lfac_gate
	import lfac_pkg::*;
#(
	parameter bit IS_DEBUG = 1'b1
) (
	input  wire logic      locked,
	input  wire logic      req_valid,
	input  wire lfac_req_t req,
	input  wire logic [7:0] raw_rdata,
	output logic           grant,
	output logic [7:0]     rdata
);
	always_comb begin
		grant = 1'b0;
		if (req_valid) begin
			if (IS_DEBUG) begin
				if (locked)
					grant = req.wr && (req.sec == LFAC_SEC_END_PRODUCT_DATA_ROW);
				else
					grant = !(req.wr && req.sec == LFAC_SEC_FACTORY_ID_ROW);
			end else begin
				grant = !(req.wr && (req.sec == LFAC_SEC_FACTORY_ID_ROW || req.sec == LFAC_SEC_FUSE ||
					req.sec == LFAC_SEC_LOCK));
			end
		end
	end
	// Refused reads still complete, but with filler instead of the stored byte.
	assign rdata = (grant && !req.wr) ? raw_rdata : `LFAC_LOCKED_FILL;
endmodule // lfac_gate

// ---- lfac_dbg_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Debug programmer model: one byte request per call, lines scrambled when idle.
module lfac_dbg_model
	import lfac_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       dbg_grant,
	input  wire logic [7:0] dbg_rdata,
	output lfac_req_t       dbg_req,
	output logic            dbg_valid,
	output logic            dbg_erase,
	output logic [7:0]      dbg_raw_rdata
);
	initial begin
		dbg_req = '0;
		dbg_valid = 1'b0;
		dbg_erase = 1'b0;
		dbg_raw_rdata = 8'h00;
	end
	task automatic access(input lfac_section_t s, input logic w, input logic [15:0] a, input logic [7:0] wd,
		input logic [7:0] raw, output logic g, output logic [7:0] rd);
		@(posedge clk);
		#1;
		// Reserved fuse bytes are always written as ones.
		dbg_req = '{sec: s, addr: a, wr: w, wdata: (s == LFAC_SEC_FUSE && a inside {3, 4}) ? 8'hff : wd};
		dbg_valid = 1'b1;
		dbg_raw_rdata = raw;
		@(posedge clk);
		#1;
		g = dbg_grant;
		rd = dbg_rdata;
		dbg_valid = 1'b0;
		dbg_req = lfac_req_t'(~dbg_req);
		dbg_raw_rdata = ~raw;
	endtask
	task automatic erase();
		@(posedge clk);
		#1;
		dbg_erase = 1'b1;
		@(posedge clk);
		#1;
		dbg_erase = 1'b0;
	endtask
endmodule // lfac_dbg_model

// ---- test_lock_fuse_access_control.sv ----
`timescale 1ns/1ps
`include "lfac_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_lock_fuse_access_control
	import lfac_pkg::*;
;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        nvm_key_valid = 1'b0;
	logic [31:0] nvm_key = '0;
	logic [71:0] nvm_fuses = '1;
	logic        cpu_valid = 1'b0;
	lfac_req_t   cpu_req = '0;
	logic [7:0]  cpu_raw_rdata = '0;
	logic        dbg_valid, dbg_erase, dbg_grant, cpu_grant, locked, startup_done, erase_busy;
	lfac_req_t   dbg_req;
	logic [7:0]  dbg_raw_rdata, dbg_rdata, cpu_rdata;
	wire logic [55:0] fo;
	logic [71:0] f1;
	int          failures = 0;
	int          n_compared = 0;
	always #20 clk = ~clk;
	lfac_dbg_model i_dbg (.clk(clk), .dbg_grant(dbg_grant), .dbg_rdata(dbg_rdata), .dbg_req(dbg_req),
		.dbg_valid(dbg_valid), .dbg_erase(dbg_erase), .dbg_raw_rdata(dbg_raw_rdata));
	lfac_lock_fuse i_dut (.clk(clk), .sys_rst(sys_rst), .nvm_key_valid(nvm_key_valid), .nvm_key(nvm_key),
		.nvm_fuses(nvm_fuses), .dbg_valid(dbg_valid), .dbg_req(dbg_req), .dbg_erase(dbg_erase),
		.dbg_raw_rdata(dbg_raw_rdata), .cpu_valid(cpu_valid), .cpu_req(cpu_req), .cpu_raw_rdata(cpu_raw_rdata),
		.locked(locked), .startup_done(startup_done), .erase_busy(erase_busy), .dbg_grant(dbg_grant),
		.dbg_rdata(dbg_rdata), .cpu_grant(cpu_grant), .cpu_rdata(cpu_rdata), .watchdog_config_fuse(fo[7:0]),
		.brownout_config_fuse(fo[15:8]), .oscillator_config_fuse(fo[23:16]), .system_config_fuse_a(fo[31:24]),
		.system_config_fuse_b(fo[39:32]), .application_section_end_fuse(fo[47:40]),
		.loader_section_end_fuse(fo[55:48]));
	function automatic logic [55:0] exp_fuse(input logic [71:0] f);
		return {f[71:40], f[23:0]};
	endfunction
	function automatic logic exp_grant(input logic lk, input logic dbg, input lfac_section_t s, input logic w);
		if (!dbg)
			return !(w && s inside {LFAC_SEC_FACTORY_ID_ROW, LFAC_SEC_FUSE, LFAC_SEC_LOCK});
		if (lk)
			return w && s == LFAC_SEC_END_PRODUCT_DATA_ROW;
		return !(w && s == LFAC_SEC_FACTORY_ID_ROW);
	endfunction
	task automatic test_done();
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic boot(input logic [31:0] k, input logic [71:0] f);
		logic       g;
		logic [7:0] rd;
		sys_rst = 1'b1;
		nvm_key_valid = 1'b0;
		nvm_key = k;
		nvm_fuses = f;
		repeat (4) @(posedge clk);
		#1;
		`CHK({locked, startup_done, fo}, {2'b10, {7{8'hff}}})
		sys_rst = 1'b0;
		i_dbg.access(LFAC_SEC_FLASH, 1'b0, 16'h0000, 8'h00, 8'h5a, g, rd);
		`CHK({g, rd}, 9'h0ff)
		nvm_key_valid = 1'b1;
		for (int n = 0; n < 20 && startup_done !== 1'b1; n++)
			@(posedge clk);
		#1;
		`CHK(startup_done, 1'b1)
		`CHK(locked, k !== `LFAC_UNLOCK_KEY)
		`CHK(fo, exp_fuse(f))
	endtask
	task automatic matrix(input logic lk);
		lfac_section_t s;
		logic          w, g;
		logic [7:0]    raw, rd;
		for (int i = 0; i < 16; i++) begin
			s = lfac_section_t'(i[2:0]);
			w = i[3];
			raw = 8'($urandom);
			i_dbg.access(s, w, 16'($urandom_range(8)), 8'($urandom), raw, g, rd);
			`CHK(g, exp_grant(lk, 1'b1, s, w))
			if (!w) `CHK(rd, exp_grant(lk, 1'b1, s, w) ? raw : `LFAC_LOCKED_FILL)
			@(posedge clk);
			#1;
			cpu_req = '{sec: s, addr: 16'($urandom), wr: w, wdata: 8'($urandom)};
			cpu_valid = 1'b1;
			cpu_raw_rdata = raw;
			@(posedge clk);
			#1;
			`CHK(cpu_grant, exp_grant(lk, 1'b0, s, w))
			if (!w) `CHK(cpu_rdata, raw)
			cpu_valid = 1'b0;
			cpu_raw_rdata = ~raw;
		end
	endtask
	initial begin
		#100000;
		failures++;
		test_done();
	end
	initial begin
		void'($urandom(55148));
		f1 = {$urandom, $urandom, $urandom};
		nvm_key = $urandom;
		boot(nvm_key == `LFAC_UNLOCK_KEY ? 32'h0 : nvm_key, f1);
		matrix(1'b1);
		nvm_fuses = ~f1;
		repeat (3) @(posedge clk);
		#1;
		`CHK(fo, exp_fuse(f1))
		i_dbg.erase();
		`CHK(erase_busy, 1'b1)
		repeat (3) @(posedge clk);
		#1;
		`CHK({erase_busy, locked}, 2'b00)
		matrix(1'b0);
		boot(`LFAC_UNLOCK_KEY ^ (32'h1 << $urandom_range(31)), f1);
		boot(`LFAC_UNLOCK_KEY, ~f1);
		test_done();
	end
endmodule // test_lock_fuse_access_control
